// ===== bench/gdc_host.sv
// controller model issuing parallel register accesses
// assumes one access per strobe and the answer one edge later
`timescale 1ns/1ps
`default_nettype none
module gdc_host (
   input  wire logic        clk_sys,   // bus clock
   input  wire logic [10:0] acc_rdata, // read answer
   output logic             acc_valid, // strobe
   output logic             acc_write, // write select
   output logic [3:0]       acc_addr,  // offset
   output logic [10:0]      acc_wdata  // write data
);
   logic [10:0] rdata;
   initial begin
      acc_valid = 1'b0;
      acc_write = 1'b0;
      acc_addr  = 4'h0;
      acc_wdata = 11'h000;
   end
   // every access also services the watchdog
   task automatic acc(input logic w, input logic [3:0] a, input logic [10:0] d);
      @(posedge clk_sys);
      #1;
      acc_valid = 1'b1;
      acc_write = w;
      acc_addr  = a;
      acc_wdata = d;
      @(posedge clk_sys);
      #1;
      acc_valid = 1'b0;
      acc_wdata = ~d; // stale data flips, never lingers
      rdata     = acc_rdata;
   endtask : acc
endmodule : gdc_host
`default_nettype wire

// ===== bench/gdc_regs_chk.sv
// checker for the control register bank ports
// assumes it is bound to every gdc_regs instance
`timescale 1ns/1ps
`default_nettype none
module gdc_regs_chk (
   input wire logic                 clk_sys,        // clock
   input wire logic                 rst,            // sync reset
   input wire logic                 acc_valid,      // strobe
   input wire logic                 acc_write,      // write select
   input wire logic [3:0]           acc_addr,       // offset
   input wire logic [10:0]          acc_wdata,      // write data
   input wire logic [10:0]          acc_rdata,      // read data
   input wire gdc_pkg::gdc_cfg_type cfg,            // settings
   input wire logic                 fault_clear,    // clear pulse
   input wire logic                 sleep_active,   // asleep
   input wire logic                 regulator_off,  // regulator down
   input wire logic                 watchdog_fault  // expired
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   logic wr9;
   logic rd;
   // decoded strobes; offset 9 excluded from reads since its clear bit self-clears
   assign wr9 = acc_valid && acc_write && acc_addr == gdc_pkg::OFS_DEV_OP;
   assign rd  = acc_valid && !acc_write && !sleep_active && acc_addr != gdc_pkg::OFS_DEV_OP;
   property p_clr;
      wr9 && acc_wdata[1] && !sleep_active |=> fault_clear ##1 !fault_clear;
   endproperty
   a_clr: assert property (p_clr) else $error("clear pulse wrong");
   property p_sleep;
      wr9 && acc_wdata[2] |=> sleep_active [*3];
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep not entered");
   property p_dflt;
      $rose(sleep_active) |-> ##[1:3] (cfg.dead_time_code == 3'h1 && cfg.amp_gain == 6'h00 && cfg.vref_scale == 2'h1);
   endproperty
   a_dflt: assert property (p_dflt) else $error("defaults not restored");
   property p_off;
      regulator_off |-> sleep_active;
   endproperty
   a_off: assert property (p_off) else $error("regulator off while awake");
   property p_rsvd;
      acc_valid && !acc_write && acc_addr == gdc_pkg::OFS_REG_SETUP |=> acc_rdata[10] == 1'b0 && acc_rdata[7:5] == 3'h0;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits read nonzero");
   property p_vref;
      acc_valid && !acc_write && acc_addr == gdc_pkg::OFS_REG_SETUP |=> acc_rdata[9:8] != 2'h0;
   endproperty
   a_vref: assert property (p_vref) else $error("scaling reads reserved code");
   property p_stable;
      rd ##2 (rd && acc_addr == $past(acc_addr, 2) && !$past(acc_valid)) |=> acc_rdata == $past(acc_rdata, 2);
   endproperty
   a_stable: assert property (p_stable) else $error("read changed contents");
   property p_wd;
      watchdog_fault && !fault_clear |=> watchdog_fault;
   endproperty
   a_wd: assert property (p_wd) else $error("watchdog fault dropped");
   property p_rect;
      cfg.rectification_active |-> cfg.pwm_input_mode == gdc_pkg::MODE_SINGLE;
   endproperty
   a_rect: assert property (p_rect) else $error("rectification outside single mode");
   c_clr: cover property (fault_clear);
   c_off: cover property (regulator_off);
   c_wd: cover property ($rose(watchdog_fault));
endmodule : gdc_regs_chk
bind gdc_regs gdc_regs_chk i_chk (.clk_sys, .rst, .acc_valid, .acc_write, .acc_addr, .acc_wdata, .acc_rdata,
   .cfg, .fault_clear, .sleep_active, .regulator_off, .watchdog_fault);
`default_nettype wire

// ===== bench/gdc_regs_tb.sv
// self-checking bench for the control register bank
// assumes gdc_pkg, the design, the host model and the checker compiled first
`timescale 1ns/1ps
`default_nettype none
module gdc_regs_tb;
   localparam logic [3:0] OFS [4] = '{gdc_pkg::OFS_GATE_SETUP, gdc_pkg::OFS_DEV_OP,
                                       gdc_pkg::OFS_AMP_SETUP, gdc_pkg::OFS_REG_SETUP};
   logic clk_sys, rst, gate_enable, extended_grade, acc_valid, acc_write;
   logic fault_clear, sleep_active, regulator_off, watchdog_fault, acc_hit;
   logic [3:0]  acc_addr;
   logic [10:0] acc_wdata, acc_rdata, d;
   logic [10:0] sh [4];
   logic [31:0] seed;
   gdc_pkg::gdc_cfg_type cfg;
   int n_fail, samples_checked, k;
   // only the short watchdog codes are shortened; the long ones are never enabled here
   gdc_regs #(.WD_CYC_0(50), .WD_CYC_1(60),
      .OFF_CYC_1(5), .OFF_CYC_2(6), .OFF_CYC_3(7)) i_dut (.clk_sys, .rst, .acc_valid, .acc_write,
      .acc_addr, .acc_wdata, .gate_enable, .extended_grade, .acc_rdata, .acc_hit, .cfg,
      .fault_clear, .sleep_active, .regulator_off, .watchdog_fault);
   gdc_host i_host (.clk_sys, .acc_rdata, .acc_valid, .acc_write, .acc_addr, .acc_wdata);
   function automatic logic [31:0] xs(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
   endfunction : xs
   // settings expected from the shadow copy of the bank
   function automatic gdc_pkg::gdc_cfg_type f_cfg();
      gdc_pkg::gdc_cfg_type c;
      c = {sh[0][10], sh[0][9] && sh[0][8:7] == 2'h2, sh[0][8:0],
           extended_grade ? sh[1][10] : ~sh[1][10], sh[1][9:7], sh[1][4], sh[1][0],
           sh[2], sh[3][9:8], sh[3][1:0], sh[3][2]};
      return c;
   endfunction : f_cfg
   task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic rd(input int s);
      i_host.acc(1'b0, OFS[s], 11'h000);
      chk("readback", i_host.rdata, sh[s]);
      chk("hit", acc_hit, 1'b1);
   endtask : rd
   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : summarize
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   // hang guard, several times the expected run
   initial begin
      #200000;
      n_fail++;
      summarize();
   end
   initial begin
      seed = 32'h3F0E47FD;
      n_fail = 0;
      samples_checked = 0;
      rst = 1'b1;
      gate_enable = 1'b0;
      extended_grade = 1'b0;
      sh = '{gdc_pkg::RST_GATE_SETUP, gdc_pkg::RST_DEV_OP, gdc_pkg::RST_AMP_SETUP, gdc_pkg::RST_REG_SETUP};
      repeat (4) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      for (int s = 0; s < 4; s++) rd(s);
      i_host.acc(1'b0, 4'h8, 11'h000);
      chk("unmapped", i_host.rdata, 11'h000);
      chk("unmapped hit", acc_hit, 1'b0);
      // random writes; sleep, clear and watchdog enable bits kept out
      for (int i = 0; i < 60; i++) begin
         seed = xs(seed);
         k = int'(seed[1:0]);
         d = seed[26:16];
         if (k == 1) d = d & 11'h7F1;
         if (k == 3 && d[9:8] == 2'h0) d[9] = 1'b1;
         gate_enable = seed[31];
         i_host.acc(1'b1, OFS[k], d);
         sh[k] = (k == 3) ? (d & 11'h31F) : d;
         rd(k);
         chk("cfg", cfg, f_cfg());
      end
      // reserved scaling code leaves the old scaling in place
      i_host.acc(1'b1, OFS[3], 11'h0FC);
      sh[3] = (sh[3] & 11'h300) | 11'h01C;
      rd(3);
      // clear pulse leaves contents alone
      i_host.acc(1'b1, OFS[1], sh[1] | 11'h002);
      chk("fault_clear", fault_clear, 1'b1);
      rd(1);
      rd(0);
      // same offset again after one idle cycle feeds the read-stability check
      rd(0);
      // watchdog at shortest delay, then left unserviced
      sh[1] = (sh[1] & 11'h79F) | 11'h008;
      i_host.acc(1'b1, OFS[1], sh[1]);
      repeat (30) @(posedge clk_sys);
      #1;
      chk("wd early", watchdog_fault, 1'b0);
      repeat (40) @(posedge clk_sys);
      #1;
      chk("wd late", watchdog_fault, 1'b1);
      sh[1] = sh[1] & 11'h7F7;
      i_host.acc(1'b1, OFS[1], sh[1] | 11'h002);
      @(posedge clk_sys);
      #1;
      chk("wd cleared", watchdog_fault, 1'b0);
      // sleep with power-down delay code 10
      sh[3] = (sh[3] & 11'h7E7) | 11'h010;
      i_host.acc(1'b1, OFS[3], sh[3]);
      i_host.acc(1'b1, OFS[1], sh[1] | 11'h004);
      chk("sleep", sleep_active, 1'b1);
      chk("reg early", regulator_off, 1'b0);
      repeat (12) @(posedge clk_sys);
      #1;
      chk("reg late", regulator_off, 1'b1);
      sh = '{gdc_pkg::RST_GATE_SETUP, gdc_pkg::RST_DEV_OP, gdc_pkg::RST_AMP_SETUP, gdc_pkg::RST_REG_SETUP};
      i_host.acc(1'b1, OFS[0], 11'h5A5);
      for (int s = 0; s < 4; s++) rd(s);
      // second reset on the extended grade, same offset after the edge as the host
      rst = 1'b1;
      extended_grade = 1'b1;
      repeat (4) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
      chk("cfg grade", cfg, f_cfg());
      summarize();
   end
endmodule : gdc_regs_tb
`default_nettype wire

// ===== hdl/gdc_pkg.sv
// package for the gate driver control register bank
// assumes a device-side register port carrying 4-bit address and 11-bit data
package gdc_pkg;
   localparam int          CLK_MHZ          = 25;
   localparam int          DATA_W           = 11;
   localparam int          ADDR_W           = 4;
   localparam logic [3:0]  OFS_GATE_SETUP   = 4'h7;
   localparam logic [3:0]  OFS_DEV_OP       = 4'h9;
   localparam logic [3:0]  OFS_AMP_SETUP    = 4'hA;
   localparam logic [3:0]  OFS_REG_SETUP    = 4'hB;
   // reset values
   localparam logic [10:0] RST_GATE_SETUP   = 11'h216;
   localparam logic [10:0] RST_DEV_OP       = 11'h020;
   localparam logic [10:0] RST_AMP_SETUP    = 11'h000;
   localparam logic [10:0] RST_REG_SETUP    = 11'h10A;
   // writable bit masks, zero marks reserved bits
   localparam logic [10:0] MASK_GATE_SETUP  = 11'h7FF;
   localparam logic [10:0] MASK_DEV_OP      = 11'h7FF;
   localparam logic [10:0] MASK_AMP_SETUP   = 11'h7FF;
   localparam logic [10:0] MASK_REG_SETUP   = 11'h31F;
   // field positions
   localparam int POS_PUMP_FREQ   = 10;
   localparam int POS_RECT        = 9;
   localparam int POS_MODE        = 7;
   localparam int POS_DEAD        = 4;
   localparam int POS_BLANK       = 2;
   localparam int POS_DEGL        = 0;
   localparam int POS_OVERTEMP_SHUTDOWN        = 10;
   localparam int POS_UV2_DIS     = 9;
   localparam int POS_DRV_DIS     = 8;
   localparam int POS_CLAMP       = 7;
   localparam int POS_WD_SEL      = 5;
   localparam int POS_OCP_DIS     = 4;
   localparam int POS_WD_ON       = 3;
   localparam int POS_SLEEP       = 2;
   localparam int POS_CLR         = 1;
   localparam int POS_PUMP_UV     = 0;
   localparam int POS_CAL         = 8;
   localparam int POS_AMP_BLANK   = 6;
   localparam int POS_GAIN        = 0;
   localparam int POS_VREF        = 8;
   localparam int POS_OFF_DLY     = 3;
   localparam int POS_VREG_UV_DIS = 2;
   localparam int POS_VREG_TRIP   = 0;
   localparam logic [1:0] MODE_SINGLE = 2'h2;
   localparam logic [1:0] VREF_RSVD   = 2'h0;
   // watchdog and power-down delays
   localparam int WD_MS_0 = 10;
   localparam int WD_MS_1 = 20;
   localparam int WD_MS_2 = 50;
   localparam int WD_MS_3 = 100;
   localparam int OFF_US_1 = 10;
   localparam int OFF_US_2 = 50;
   localparam int OFF_US_3 = 1000;
   localparam int WD_CYC_0  = WD_MS_0 * 1000 * CLK_MHZ;
   localparam int WD_CYC_1  = WD_MS_1 * 1000 * CLK_MHZ;
   localparam int WD_CYC_2  = WD_MS_2 * 1000 * CLK_MHZ;
   localparam int WD_CYC_3  = WD_MS_3 * 1000 * CLK_MHZ;
   localparam int OFF_CYC_1 = OFF_US_1 * CLK_MHZ;
   localparam int OFF_CYC_2 = OFF_US_2 * CLK_MHZ;
   localparam int OFF_CYC_3 = OFF_US_3 * CLK_MHZ;
   localparam int CNT_W     = 28;

   // settings passed to the analog front
   typedef struct packed {
      logic       pump_freq_select;
      logic       rectification_active;
      logic [1:0] pwm_input_mode;
      logic [2:0] dead_time_code;
      logic [1:0] sense_blank_time;
      logic [1:0] sense_deglitch_time;
      logic       overtemp_shutdown;
      logic       supply_uv2_disable;
      logic       drive_fault_disable;
      logic       amp_clamp_enable;
      logic       shunt_overcurrent_disable;
      logic       pump_uv_threshold_sel;
      logic [2:0] amp_calibrate;
      logic [1:0] amp_blank_time;
      logic [5:0] amp_gain;
      logic [1:0] vref_scale;
      logic [1:0] regulator_uv_trip;
      logic       regulator_uv_disable;
   } gdc_cfg_type;
endpackage : gdc_pkg

// ===== hdl/gdc_regs.sv
// gate driver control register bank: four 11-bit settings registers
// assumes the serial frame decoder hands over one parallel access per strobe
`timescale 1ns/1ps
`default_nettype none
module gdc_regs #(
   parameter int WD_CYC_0  = gdc_pkg::WD_CYC_0,  // 10 ms timeout in cycles
   parameter int WD_CYC_1  = gdc_pkg::WD_CYC_1,  // 20 ms
   parameter int WD_CYC_2  = gdc_pkg::WD_CYC_2,  // 50 ms
   parameter int WD_CYC_3  = gdc_pkg::WD_CYC_3,  // 100 ms
   parameter int OFF_CYC_1 = gdc_pkg::OFF_CYC_1, // 10 us power-down delay
   parameter int OFF_CYC_2 = gdc_pkg::OFF_CYC_2, // 50 us
   parameter int OFF_CYC_3 = gdc_pkg::OFF_CYC_3  // 1 ms
) (
   input  wire logic                       clk_sys,        // 25 MHz clock
   input  wire logic                       rst,            // power-up reset, sync high
   input  wire logic                       acc_valid,      // one-cycle access strobe
   input  wire logic                       acc_write,      // 1 write, 0 read
   input  wire logic [gdc_pkg::ADDR_W-1:0] acc_addr,       // register offset
   input  wire logic [gdc_pkg::DATA_W-1:0] acc_wdata,      // write data
   input  wire logic                       gate_enable,    // gate enable pin, async
   input  wire logic                       extended_grade, // strap: extended grade part
   output logic [gdc_pkg::DATA_W-1:0]      acc_rdata,      // read data, held
   output logic                            acc_hit,        // last access mapped
   output gdc_pkg::gdc_cfg_type            cfg,            // settings to analog front
   output logic                            fault_clear,    // one-cycle clear pulse
   output logic                            sleep_active,   // device asleep
   output logic                            regulator_off,  // regulator powered down
   output logic                            watchdog_fault  // watchdog expired, sticky
);
   typedef enum logic [1:0] {ST_AWAKE, ST_WAIT_OFF, ST_ASLEEP} gdc_pwr_type;

   logic [10:0] gate_q, devop_q, amp_q, vreg_q;
   logic [10:0] rd_d;
   logic        hit_d;
   logic        wr_gate, wr_devop, wr_amp, wr_vreg;
   logic        en_s1_q, en_s2_q, en_s3_q;
   logic        grade_q;
   logic        sleep_go;
   logic        wd_run, wd_done, wd_load;
   logic        off_run, off_done, off_load;
   logic [gdc_pkg::CNT_W-1:0] wd_cnt, off_cnt;
   logic [1:0]  mode;
   gdc_pwr_type pwr_q;

   assign wr_gate  = acc_valid && acc_write && (acc_addr == gdc_pkg::OFS_GATE_SETUP);
   assign wr_devop = acc_valid && acc_write && (acc_addr == gdc_pkg::OFS_DEV_OP);
   assign wr_amp   = acc_valid && acc_write && (acc_addr == gdc_pkg::OFS_AMP_SETUP);
   assign wr_vreg  = acc_valid && acc_write && (acc_addr == gdc_pkg::OFS_REG_SETUP);
   assign sleep_go = wr_devop && acc_wdata[gdc_pkg::POS_SLEEP] && (pwr_q == ST_AWAKE);

   // gate enable pin synchroniser; its output drives nothing and never clears settings
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         en_s1_q <= 1'b0;
         en_s2_q <= 1'b0;
         en_s3_q <= 1'b0;
      end else begin
         en_s1_q <= gate_enable;
         en_s2_q <= en_s1_q;
         en_s3_q <= en_s2_q;
      end
   end

   // grade strap caught while reset is held, clocked so reset stays constant-only
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         grade_q <= extended_grade;
      end
   end

   // gate drive setup register
   always_ff @(posedge clk_sys) begin
      if (rst || sleep_active) begin
         gate_q <= gdc_pkg::RST_GATE_SETUP;
      end else if (wr_gate) begin
         gate_q <= acc_wdata & gdc_pkg::MASK_GATE_SETUP;
      end
   end

   // device operation register; fault clear self-returns so it acts once per write
   always_ff @(posedge clk_sys) begin
      if (rst || sleep_active) begin
         devop_q <= gdc_pkg::RST_DEV_OP;
      end else if (wr_devop) begin
         devop_q <= acc_wdata & gdc_pkg::MASK_DEV_OP;
      end else begin
         devop_q[gdc_pkg::POS_CLR] <= 1'b0;
      end
   end

   // current amplifier setup register
   always_ff @(posedge clk_sys) begin
      if (rst || sleep_active) begin
         amp_q <= gdc_pkg::RST_AMP_SETUP;
      end else if (wr_amp) begin
         amp_q <= acc_wdata & gdc_pkg::MASK_AMP_SETUP;
      end
   end

   // regulator setup; a reserved scaling code keeps the old value
   always_ff @(posedge clk_sys) begin
      if (rst || sleep_active) begin
         vreg_q <= gdc_pkg::RST_REG_SETUP;
      end else if (wr_vreg) begin
         vreg_q <= acc_wdata & gdc_pkg::MASK_REG_SETUP;
         if (acc_wdata[gdc_pkg::POS_VREF +: 2] == gdc_pkg::VREF_RSVD) begin
            vreg_q[gdc_pkg::POS_VREF +: 2] <= vreg_q[gdc_pkg::POS_VREF +: 2];
         end
      end
   end

   // read mux; reads leave the register contents unchanged and unmapped offsets return zero
   always_comb begin
      rd_d  = '0;
      hit_d = 1'b1;
      unique case (acc_addr)
         gdc_pkg::OFS_GATE_SETUP: rd_d = gate_q;
         gdc_pkg::OFS_DEV_OP:     rd_d = devop_q;
         gdc_pkg::OFS_AMP_SETUP:  rd_d = amp_q;
         gdc_pkg::OFS_REG_SETUP:  rd_d = vreg_q;
         default:                 hit_d = 1'b0;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         acc_rdata <= '0;
         acc_hit   <= 1'b0;
      end else if (acc_valid) begin
         acc_rdata <= acc_write ? acc_rdata : rd_d;
         acc_hit   <= hit_d;
      end
   end

   // settings decode toward the analog front
   assign mode = gate_q[gdc_pkg::POS_MODE +: 2];
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cfg <= '0;
      end else begin
         cfg.pump_freq_select     <= gate_q[gdc_pkg::POS_PUMP_FREQ];
         cfg.rectification_active <= (mode == gdc_pkg::MODE_SINGLE)
                                     && gate_q[gdc_pkg::POS_RECT];
         cfg.pwm_input_mode       <= mode;
         cfg.dead_time_code       <= gate_q[gdc_pkg::POS_DEAD +: 3];
         cfg.sense_blank_time     <= gate_q[gdc_pkg::POS_BLANK +: 2];
         cfg.sense_deglitch_time  <= gate_q[gdc_pkg::POS_DEGL +: 2];
         // shutdown active sense flips with the grade strap
         cfg.overtemp_shutdown    <= devop_q[gdc_pkg::POS_OVERTEMP_SHUTDOWN] ^ ~grade_q;
         cfg.supply_uv2_disable   <= devop_q[gdc_pkg::POS_UV2_DIS];
         cfg.drive_fault_disable  <= devop_q[gdc_pkg::POS_DRV_DIS];
         cfg.amp_clamp_enable     <= devop_q[gdc_pkg::POS_CLAMP];
         cfg.shunt_overcurrent_disable <= devop_q[gdc_pkg::POS_OCP_DIS];
         cfg.pump_uv_threshold_sel <= devop_q[gdc_pkg::POS_PUMP_UV];
         cfg.amp_calibrate        <= amp_q[gdc_pkg::POS_CAL +: 3];
         cfg.amp_blank_time       <= amp_q[gdc_pkg::POS_AMP_BLANK +: 2];
         cfg.amp_gain             <= amp_q[gdc_pkg::POS_GAIN +: 6];
         cfg.vref_scale           <= vreg_q[gdc_pkg::POS_VREF +: 2];
         cfg.regulator_uv_trip    <= vreg_q[gdc_pkg::POS_VREG_TRIP +: 2];
         cfg.regulator_uv_disable <= vreg_q[gdc_pkg::POS_VREG_UV_DIS];
      end
   end

   // fault clear pulse follows a write of one
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         fault_clear <= 1'b0;
      end else begin
         fault_clear <= wr_devop && acc_wdata[gdc_pkg::POS_CLR];
      end
   end

   // watchdog timeout select; any access, read or write at any offset, services it
   always_comb begin
      unique case (devop_q[gdc_pkg::POS_WD_SEL +: 2])
         2'h0:    wd_cnt = gdc_pkg::CNT_W'(WD_CYC_0);
         2'h1:    wd_cnt = gdc_pkg::CNT_W'(WD_CYC_1);
         2'h2:    wd_cnt = gdc_pkg::CNT_W'(WD_CYC_2);
         default: wd_cnt = gdc_pkg::CNT_W'(WD_CYC_3);
      endcase
   end
   assign wd_load = devop_q[gdc_pkg::POS_WD_ON] && (acc_valid || !wd_run) && !wd_done;

   gdc_timer u_wd (
      .clk_sys (clk_sys),
      .rst     (rst),
      .load    (wd_load),
      .stop    (!devop_q[gdc_pkg::POS_WD_ON]),
      .count   (wd_cnt),
      .running (wd_run),
      .done    (wd_done)
   );

   // watchdog expiry latches until fault clear; expiry wins a same-cycle clear
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         watchdog_fault <= 1'b0;
      end else if (wd_done) begin
         watchdog_fault <= 1'b1;
      end else if (fault_clear) begin
         watchdog_fault <= 1'b0;
      end
   end

   // power-down delay select, taken from the regulator setup register when sleep is requested
   always_comb begin
      unique case (vreg_q[gdc_pkg::POS_OFF_DLY +: 2])
         2'h0:    off_cnt = gdc_pkg::CNT_W'(1);
         2'h1:    off_cnt = gdc_pkg::CNT_W'(OFF_CYC_1);
         2'h2:    off_cnt = gdc_pkg::CNT_W'(OFF_CYC_2);
         default: off_cnt = gdc_pkg::CNT_W'(OFF_CYC_3);
      endcase
   end
   assign off_load = sleep_go;

   gdc_timer u_off (
      .clk_sys (clk_sys),
      .rst     (rst),
      .load    (off_load),
      .stop    (1'b0),
      .count   (off_cnt),
      .running (off_run),
      .done    (off_done)
   );

   // sleep sequence: registers default at entry, regulator drops after the delay;
   // leaving sleep needs the power-up reset
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pwr_q         <= ST_AWAKE;
         sleep_active  <= 1'b0;
         regulator_off <= 1'b0;
      end else begin
         unique case (pwr_q)
            ST_AWAKE: begin
               if (sleep_go) begin
                  pwr_q        <= ST_WAIT_OFF;
                  sleep_active <= 1'b1;
               end
            end
            ST_WAIT_OFF: begin
               if (off_done) begin
                  pwr_q         <= ST_ASLEEP;
                  regulator_off <= 1'b1;
               end
            end
            ST_ASLEEP: begin
               regulator_off <= 1'b1;
            end
         endcase
      end
   end
endmodule : gdc_regs
`default_nettype wire

// ===== hdl/gdc_timer.sv
// down-counting timer: load a count, pulses done when it reaches zero
// assumes a synchronous active high reset on clk_sys
`timescale 1ns/1ps
`default_nettype none
module gdc_timer (
   input  wire logic                     clk_sys, // system clock
   input  wire logic                     rst,     // synchronous reset
   input  wire logic                     load,    // restart with count
   input  wire logic                     stop,    // abandon count
   input  wire logic [gdc_pkg::CNT_W-1:0] count,  // cycles to wait
   output logic                          running, // count in progress
   output logic                          done     // one-cycle expiry pulse
);
   logic [gdc_pkg::CNT_W-1:0] cnt_q;

   // load wins over stop so a service never gets lost
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cnt_q   <= '0;
         running <= 1'b0;
         done    <= 1'b0;
      end else if (load) begin
         cnt_q   <= count;
         running <= 1'b1;
         done    <= 1'b0;
      end else if (stop) begin
         running <= 1'b0;
         done    <= 1'b0;
      end else if (running) begin
         done <= (cnt_q <= gdc_pkg::CNT_W'(1));
         if (cnt_q <= gdc_pkg::CNT_W'(1)) begin
            running <= 1'b0;
         end
         cnt_q <= cnt_q - gdc_pkg::CNT_W'(1);
      end else begin
         done <= 1'b0;
      end
   end
endmodule : gdc_timer
`default_nettype wire
